//--- bench/sdes_chk.sv
`include "sdes_regs.svh"

// ----------------------------------------------------------------
// Port checker for the drop status block
// ----------------------------------------------------------------
module sdes_chk (
  // Clock and reset
  input logic                    clk_sys_i,
  input logic                    arst_n_i,
  // Drop reports
  input logic                    drop_valid_i,
  input logic [3:0]              drop_reason_i,
  input logic [1:0]              drop_port_i,
  // Register port
  input logic [`SDES_ADDR_W-1:0] reg_addr_i,
  input logic                    reg_rd_i,
  input logic                    reg_wr_i,
  input logic [31:0]             reg_wdata_i,
  input logic [31:0]             reg_rdata_o,
  input logic                    reg_ack_o,
  input logic                    irq_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // Pending read taken, and pending read at the last edge
  logic rd_pend;
  logic rd_q;
  assign rd_pend = reg_rd_i && (reg_addr_i == `SDES_ADDR_PEND);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_pend;
    end
  end

  a_ack_follows: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o)
    else $error("access not acknowledged");
  a_ack_cause: assert property (reg_ack_o |-> $past(reg_rd_i || reg_wr_i))
    else $error("acknowledge without access");
  a_upper_zero: assert property (reg_ack_o && rd_q |-> reg_rdata_o[31:14] == 18'h0)
    else $error("pending upper bits not zero");
  a_b_legal: assert property (
    reg_ack_o && rd_q && reg_rdata_o[7] |->
    reg_rdata_o[13:10] inside {[4'h0:4'h6], 4'h9} && reg_rdata_o[9:8] != 2'h3)
    else $error("slot B holds a reserved value");
  a_a_legal: assert property (
    reg_ack_o && rd_q && reg_rdata_o[0] |->
    reg_rdata_o[6:3] inside {[4'h0:4'h6], 4'h9} && reg_rdata_o[2:1] != 2'h3)
    else $error("slot A holds a reserved value");
  a_empty_zero: assert property (
    reg_ack_o && rd_q && !reg_rdata_o[0] |-> reg_rdata_o[13:1] == 13'h0)
    else $error("empty slot A with other bits set");
  a_clear_read: assert property (
    (rd_pend && !drop_valid_i) ##1 rd_pend |=> reg_rdata_o == 32'h0)
    else $error("read did not clear the slots");
  a_irq_drops: assert property ((rd_pend && !drop_valid_i) ##1 !drop_valid_i |=> !irq_o)
    else $error("interrupt stayed up after clear");
  a_mask_rdata: assert property (
    reg_ack_o && $past(reg_rd_i && reg_addr_i == `SDES_ADDR_MASK)
    |-> reg_rdata_o[31:1] == 31'h0)
    else $error("mask upper bits not zero");

  // Main scenarios reached
  c_both: cover property (reg_ack_o && rd_q && reg_rdata_o[7]);
  c_irq: cover property ($rose(irq_o));
  c_back: cover property (rd_pend ##1 rd_pend);
endmodule

bind sdes_top sdes_chk u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .drop_valid_i(drop_valid_i), .drop_reason_i(drop_reason_i), .drop_port_i(drop_port_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
  .irq_o(irq_o));

//--- bench/tb_top.sv
`include "sdes_regs.svh"

// ----------------------------------------------------------------
// Self-checking bench for the drop status block
// ----------------------------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys_i, arst_n_i, drop_valid_i, reg_rd_i, reg_wr_i;
  logic [3:0]  drop_reason_i;
  logic [1:0]  drop_port_i;
  logic [15:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic        reg_ack_o, irq_o;
  int          err_count, num_checks, cyc;
  logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  logic [31:0] exp_w;  // Expected pending image

  sdes_top DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .drop_valid_i(drop_valid_i),
    .drop_reason_i(drop_reason_i), .drop_port_i(drop_port_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .irq_o(irq_o));

  // Clock at 100 ns
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Packed slot image: reason, port, valid
  function automatic logic [6:0] slot(input logic [3:0] r, input logic [1:0] p);
    return {r, p, 1'b1};
  endfunction

  // One drop report pulse
  task automatic drop(input logic [3:0] r, input logic [1:0] p);
    @(posedge clk_sys_i);
    drop_valid_i  <= 1'b1;
    drop_reason_i <= r;
    drop_port_i   <= p;
    @(posedge clk_sys_i);
    drop_valid_i <= 1'b0;
  endtask

  // Register access; strobe taken at the second edge, answer just after it
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wr_i    <= w;
    reg_rd_i    <= !w;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 chk({31'h0, reg_ack_o}, 32'h1);
    if (!w) chk(reg_rdata_o, exp);
  endtask

  // Closing verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {arst_n_i, drop_valid_i, reg_rd_i, reg_wr_i, drop_reason_i, drop_port_i} = '0;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 32'h0000_0000;
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    // Reset values and masked interrupt
    acc(1'b0, `SDES_ADDR_PEND, 32'h0, 32'h0);
    acc(1'b0, `SDES_ADDR_MASK, 32'h0, 32'h1);
    drop(4'h2, 2'h1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk({31'h0, irq_o}, 32'h0);
    acc(1'b0, `SDES_ADDR_PEND, 32'h0, {25'h0, slot(4'h2, 2'h1)});
    $display("test 1 done");
    // Every reason code and port through slot A
    for (int i = 0; i < 8; i++) begin
      drop(codes[i], 2'(i % 3));
      exp_w = {25'h0, slot(codes[i], 2'(i % 3))};
      acc(1'b0, `SDES_ADDR_PEND, 32'h0, exp_w);
    end
    $display("test 2 done");
    // Two slots, third drop lost, back-to-back reads clear
    drop(4'h6, 2'h2);
    drop(4'h9, 2'h0);
    drop(4'h1, 2'h1);
    @(posedge clk_sys_i) begin reg_addr_i <= `SDES_ADDR_PEND; reg_rd_i <= 1'b1; end
    @(posedge clk_sys_i);
    exp_w = {18'h0, slot(4'h9, 2'h0), slot(4'h6, 2'h2)};
    #1 chk(reg_rdata_o, exp_w);
    @(posedge clk_sys_i) reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, 32'h0);
    $display("test 3 done");
    // Reserved codes and port never captured
    drop(4'h7, 2'h0);
    drop(4'hF, 2'h1);
    drop(4'h2, 2'h3);
    acc(1'b0, `SDES_ADDR_PEND, 32'h0, 32'h0);
    $display("test 4 done");
    // Unmask, raise, mask again; status kept; ignored writes and unmapped read
    acc(1'b1, `SDES_ADDR_MASK, 32'h0, 32'h0);
    acc(1'b0, `SDES_ADDR_MASK, 32'h0, 32'h0);
    drop(4'h3, 2'h1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk({31'h0, irq_o}, 32'h1);
    acc(1'b1, `SDES_ADDR_MASK, 32'h1, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk({31'h0, irq_o}, 32'h0);
    acc(1'b1, `SDES_ADDR_PEND, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, `SDES_ADDR_PEND, 32'h0, {25'h0, slot(4'h3, 2'h1)});
    acc(1'b0, 16'h1C22, 32'h0, 32'h0);
    $display("test 5 done");
    // Read and drop in one cycle: old image returned, new drop kept
    drop(4'h5, 2'h2);
    @(posedge clk_sys_i);
    drop_valid_i  <= 1'b1;
    drop_reason_i <= 4'h1;
    drop_port_i   <= 2'h0;
    reg_addr_i    <= `SDES_ADDR_PEND;
    reg_rd_i      <= 1'b1;
    @(posedge clk_sys_i);
    drop_valid_i <= 1'b0;
    reg_rd_i     <= 1'b0;
    exp_w = {25'h0, slot(4'h5, 2'h2)};
    #1 chk(reg_rdata_o, exp_w);
    exp_w = {25'h0, slot(4'h1, 2'h0)};
    acc(1'b0, `SDES_ADDR_PEND, 32'h0, exp_w);
    $display("test 6 done");
    // Mid-run reset empties the slots and sets the mask again
    acc(1'b1, `SDES_ADDR_MASK, 32'h0, 32'h0);
    drop(4'h2, 2'h0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk({31'h0, irq_o}, 32'h1);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    #1 chk({31'h0, irq_o}, 32'h0);
    acc(1'b0, `SDES_ADDR_PEND, 32'h0, 32'h0);
    acc(1'b0, `SDES_ADDR_MASK, 32'h0, 32'h1);
    $display("test 7 done");
    final_report();
  end
endmodule

//--- rtl/sdes_pkg.sv
package sdes_pkg;

  // ----------------------------------------------------------------
  // Drop reason codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SDES_RSN_BCAST_LEVEL = 4'h0,  // Unknown/broadcast, level exceeded
    SDES_RSN_RED         = 4'h1,  // Drop on red
    SDES_RSN_NO_BUF      = 4'h2,  // No free buffers
    SDES_RSN_NO_DESC     = 4'h3,  // No free descriptors
    SDES_RSN_NO_DEST     = 4'h4,  // Unknown/broadcast, no destination
    SDES_RSN_RX_ERR      = 4'h5,  // Receive error, longer than 64 bytes
    SDES_RSN_DROP_LEVEL  = 4'h6,  // Buffer drop level exceeded
    SDES_RSN_YELLOW      = 4'h9   // Random yellow discard
  } sdes_reason_t;

  // ----------------------------------------------------------------
  // Source port codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDES_PORT_0 = 2'h0,
    SDES_PORT_1 = 2'h1,
    SDES_PORT_2 = 2'h2
  } sdes_port_t;

  // ----------------------------------------------------------------
  // Legal reason code check
  // ----------------------------------------------------------------
  function automatic logic sdes_reason_legal(input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      SDES_RSN_BCAST_LEVEL,
      SDES_RSN_RED,
      SDES_RSN_NO_BUF,
      SDES_RSN_NO_DESC,
      SDES_RSN_NO_DEST,
      SDES_RSN_RX_ERR,
      SDES_RSN_DROP_LEVEL,
      SDES_RSN_YELLOW: ok = 1'b1;
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

//--- rtl/sdes_regs.svh
`ifndef SDES_REGS_SVH
`define SDES_REGS_SVH

// ----------------------------------------------------------------
// Register numbers on the management interface
// ----------------------------------------------------------------
`define SDES_ADDR_W          16
`define SDES_ADDR_MASK       16'h1C20
`define SDES_ADDR_PEND       16'h1C21

// ----------------------------------------------------------------
// Pending register field positions
// ----------------------------------------------------------------
`define SDES_B_REASON_MSB    13
`define SDES_B_REASON_LSB    10
`define SDES_B_PORT_MSB      9
`define SDES_B_PORT_LSB      8
`define SDES_B_VALID_BIT     7
`define SDES_A_REASON_MSB    6
`define SDES_A_REASON_LSB    3
`define SDES_A_PORT_MSB      2
`define SDES_A_PORT_LSB      1
`define SDES_A_VALID_BIT     0

// ----------------------------------------------------------------
// Mask register field, reset values and reserved port code
// ----------------------------------------------------------------
`define SDES_MASK_BIT        0
`define SDES_MASK_RESET      1'h1
`define SDES_PORT_RESERVED   2'h3
`define SDES_DATA_ZERO       32'h0000_0000

`endif

//--- rtl/sdes_slot.sv
// ----------------------------------------------------------------
// One capture slot: reason, port and valid flag
// ----------------------------------------------------------------
module sdes_slot (
  // Clock and reset
  input  wire logic  clk_sys_i,
  input  wire logic  arst_n_i,
  // Control and held contents
  sdes_slot_if.slot  sl
);

  logic       valid;        // Slot occupied
  logic [3:0] reason;       // Held reason
  logic [1:0] port;         // Held port
  logic       next_valid;
  logic [3:0] next_reason;
  logic [1:0] next_port;

  // Next state: a capture wins over a clear in the same cycle
  always_comb begin
    next_valid  = valid;
    next_reason = reason;
    next_port   = port;
    if (sl.load) begin
      next_valid  = 1'b1;
      next_reason = sl.reason_in;
      next_port   = sl.port_in;
    end else if (sl.clear) begin
      next_valid  = 1'b0;
      next_reason = '0;
      next_port   = '0;
    end
  end

  // Slot registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid  <= 1'b0;
      reason <= '0;
      port   <= '0;
    end else begin
      valid  <= next_valid;
      reason <= next_reason;
      port   <= next_port;
    end
  end

  assign sl.valid  = valid;
  assign sl.reason = reason;
  assign sl.port   = port;

endmodule

//--- rtl/sdes_slot_if.sv
// ----------------------------------------------------------------
// Link between the status logic and one capture slot
// ----------------------------------------------------------------
interface sdes_slot_if;
  logic       load;       // Capture the offered drop this cycle
  logic       clear;      // Read clears the slot
  logic [3:0] reason_in;  // Offered reason code
  logic [1:0] port_in;    // Offered source port
  logic       valid;      // Slot holds a drop
  logic [3:0] reason;     // Held reason code
  logic [1:0] port;       // Held source port

  // Controlling side
  modport ctrl (
    output load, clear, reason_in, port_in,
    input  valid, reason, port
  );

  // Slot side
  modport slot (
    input  load, clear, reason_in, port_in,
    output valid, reason, port
  );
endinterface

//--- rtl/sdes_top.sv
`include "sdes_regs.svh"

// ----------------------------------------------------------------
// Drop event status with two capture slots and a global mask
// ----------------------------------------------------------------
module sdes_top (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    arst_n_i,
  // Drop reports from the buffer manager
  input  wire logic                    drop_valid_i,
  input  wire logic [3:0]              drop_reason_i,
  input  wire logic [1:0]              drop_port_i,
  // Management register port
  input  wire logic [`SDES_ADDR_W-1:0] reg_addr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [31:0]             reg_wdata_i,
  output logic      [31:0]             reg_rdata_o,
  output logic                         reg_ack_o,
  // Interrupt to the system
  output logic                         irq_o
);

  // ----------------------------------------------------------------
  // Slot links
  // ----------------------------------------------------------------
  sdes_slot_if slot_a ();  // First capture slot
  sdes_slot_if slot_b ();  // Second capture slot

  // ----------------------------------------------------------------
  // Decode and event qualification
  // ----------------------------------------------------------------
  logic event_ok;   // Drop report with legal code and port
  logic hit_pend;   // Access to the pending register
  logic hit_mask;   // Access to the mask register
  logic rd_pend;    // Clear-on-read of the pending register

  // Reserved reason codes and port 11 are never captured
  assign event_ok = drop_valid_i
                 && sdes_pkg::sdes_reason_legal(drop_reason_i)
                 && (drop_port_i != `SDES_PORT_RESERVED);

  // Register decode
  always_comb begin
    hit_pend = 1'b0;
    hit_mask = 1'b0;
    if (reg_addr_i == `SDES_ADDR_PEND) begin
      hit_pend = 1'b1;
    end else if (reg_addr_i == `SDES_ADDR_MASK) begin
      hit_mask = 1'b1;
    end
  end

  assign rd_pend = reg_rd_i && hit_pend;

  // ----------------------------------------------------------------
  // Slot fill policy
  // ----------------------------------------------------------------
  // Slot A takes a drop when empty or being cleared by this read,
  // slot B only when A stays full and B is empty; a third drop is lost
  always_comb begin
    slot_a.reason_in = drop_reason_i;
    slot_a.port_in   = drop_port_i;
    slot_b.reason_in = drop_reason_i;
    slot_b.port_in   = drop_port_i;
    slot_a.clear     = rd_pend;
    slot_b.clear     = rd_pend;
    slot_a.load      = event_ok && (!slot_a.valid || rd_pend);
    slot_b.load      = event_ok && slot_a.valid && !rd_pend
                    && !slot_b.valid;
  end

  // ----------------------------------------------------------------
  // Capture slots
  // ----------------------------------------------------------------
  sdes_slot u_slot_a (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .sl        (slot_a)
  );

  sdes_slot u_slot_b (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .sl        (slot_b)
  );

  // ----------------------------------------------------------------
  // Pending word assembly
  // ----------------------------------------------------------------
  logic [31:0] pend_word;  // Pending register image

  // Reserved bits 31:14 read as zero
  always_comb begin
    pend_word = `SDES_DATA_ZERO;
    pend_word[`SDES_B_REASON_MSB:`SDES_B_REASON_LSB] = slot_b.reason;
    pend_word[`SDES_B_PORT_MSB:`SDES_B_PORT_LSB]     = slot_b.port;
    pend_word[`SDES_B_VALID_BIT]                     = slot_b.valid;
    pend_word[`SDES_A_REASON_MSB:`SDES_A_REASON_LSB] = slot_a.reason;
    pend_word[`SDES_A_PORT_MSB:`SDES_A_PORT_LSB]     = slot_a.port;
    pend_word[`SDES_A_VALID_BIT]                     = slot_a.valid;
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  logic mask;       // Global interrupt mask
  logic next_mask;

  // Write updates the mask; it never touches captured status
  always_comb begin
    next_mask = mask;
    if (reg_wr_i && hit_mask) begin
      next_mask = reg_wdata_i[`SDES_MASK_BIT];
    end
  end

  // Mask is set out of reset so nothing escapes before setup
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask <= `SDES_MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // Register port answer and interrupt
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic        next_ack;
  logic        next_irq;

  // Read data holds its value until the next read; writes only ack
  always_comb begin
    next_rdata = reg_rdata_o;
    next_ack   = reg_rd_i || reg_wr_i;
    if (reg_rd_i) begin
      if (hit_pend) begin
        next_rdata = pend_word;
      end else if (hit_mask) begin
        next_rdata = `SDES_DATA_ZERO;
        next_rdata[`SDES_MASK_BIT] = mask;
      end else begin
        next_rdata = `SDES_DATA_ZERO;
      end
    end
    // Any pending slot raises the line unless globally masked
    next_irq = (slot_a.valid || slot_b.valid) && !mask;
  end

  // Output registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= `SDES_DATA_ZERO;
      reg_ack_o   <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      reg_rdata_o <= next_rdata;
      reg_ack_o   <= next_ack;
      irq_o       <= next_irq;
    end
  end

endmodule
